// ===== hdlc_tx_input_interface_test.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Testbench: terminal and transmitter face each other
module hdlc_tx_input_interface_test;
  // Clock, reset and configuration
  logic clk;
  logic resetn;
  logic tbus_en;
  logic hdlc_mode_en;
  logic crc32_sel;
  // User byte offer
  logic [7:0] frame_byte;
  logic frame_byte_valid;
  logic frame_byte_last;
  // Observed outputs
  logic frame_byte_ready, frame_done, term_busy;
  logic [7:0] payload_byte;
  logic payload_valid, payload_is_data, frame_active;
  // Counters and captured frame octets, top bit marks content
  int error_cnt = 0;
  int compares = 0;
  logic [8:0] cap_q[$];
  // Previous framer octet lay inside a frame
  logic was_act = 1'b0;
  hht_if link ();
  hht_term u_hht_term (.clk(clk), .resetn(resetn), .link(link), .hdlc_mode_en(hdlc_mode_en),
    .crc32_sel(crc32_sel), .frame_byte(frame_byte), .frame_byte_valid(frame_byte_valid),
    .frame_byte_last(frame_byte_last), .frame_byte_ready(frame_byte_ready),
    .frame_done(frame_done), .term_busy(term_busy));
  hht_dev u_hht_dev (.clk(clk), .resetn(resetn), .link(link), .tbus_en(tbus_en),
    .hdlc_mode_en(hdlc_mode_en), .crc32_sel(crc32_sel), .payload_byte(payload_byte),
    .payload_valid(payload_valid), .payload_is_data(payload_is_data),
    .frame_active(frame_active));
  hht_checker u_hht_checker (.clk(clk), .resetn(resetn), .hdlc_tx_clk(link.hdlc_tx_clk),
    .msg_send_cmd(link.msg_send_cmd), .fcs_insert_cmd(link.fcs_insert_cmd),
    .hdlc_tx_byte_in(link.hdlc_tx_byte_in));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compare and count
  task chk(input logic c, input string m);
    compares++;
    if (c !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  // Verdict and end of run
  task tally_and_finish;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Capture frame octets, check idle octets on the fly
  // The active flag drops with the closing trailer octet, so that octet is kept too
  always @(posedge clk) begin
    if (resetn === 1'b1 && payload_valid === 1'b1) begin
      if (frame_active === 1'b1 || was_act === 1'b1) begin
        cap_q.push_back({payload_is_data, payload_byte});
      end else begin
        chk(payload_byte === 8'h7E && payload_is_data === 1'b0, "idle octet");
      end
      was_act <= (frame_active === 1'b1);
    end
  end
  // Offer bytes one by one, then wait for frame end
  task automatic send(input logic [7:0] d[$]);
    int n;
    for (int i = 0; i < d.size(); i++) begin
      frame_byte <= d[i];
      frame_byte_valid <= 1'b1;
      frame_byte_last <= (i == d.size() - 1);
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (frame_byte_ready !== 1'b1 && n < 100);
      chk(n < 100, "byte not taken");
      chk(term_busy === 1'b1, "not busy in frame");
    end
    frame_byte_valid <= 1'b0;
    frame_byte_last <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (frame_done !== 1'b1 && n < 200);
    chk(n < 200, "frame never done");
    chk(term_busy === 1'b0, "busy after frame");
    repeat (20) @(posedge clk);
  endtask
  // Send a frame and compare content plus trailer
  task automatic run_frame(input logic [7:0] d[$], input logic c32);
    logic [31:0] crc;
    logic [8:0] exp_q[$];
    crc = c32 ? hht_pkg::CRC32_INIT : hht_pkg::CRC16_INIT;
    foreach (d[i]) begin
      exp_q.push_back({1'b1, d[i]});
      crc = crc ^ {24'h000000, d[i]};
      repeat (8) crc = crc[0] ? ((crc >> 1) ^ (c32 ? 32'hEDB88320 : 32'h00008408)) : (crc >> 1);
    end
    crc = ~crc;
    for (int k = 0; k < (c32 ? 4 : 2); k++) exp_q.push_back({1'b0, crc[8*k +: 8]});
    crc32_sel <= c32;
    cap_q.delete();
    send(d);
    chk(cap_q.size() == exp_q.size(), "frame length");
    foreach (exp_q[i]) chk(cap_q[i] === exp_q[i], "frame octet");
  endtask
  // Idle link sends only flags
  task test_idle;
    repeat (40) @(posedge clk);
    chk(cap_q.size() == 0, "frame while idle");
    $display("test idle done");
  endtask
  // Telecom bus on: port ignored
  task test_tbus;
    tbus_en <= 1'b1;
    cap_q.delete();
    send('{8'h11, 8'h22});
    chk(cap_q.size() == 0, "port used with bus on");
    tbus_en <= 1'b0;
    $display("test tbus done");
  endtask
  // Mode off: no take, trailer pin low
  task test_mode_off;
    hdlc_mode_en <= 1'b0;
    frame_byte_valid <= 1'b1;
    repeat (40) begin
      @(posedge clk);
      chk(frame_byte_ready === 1'b0 && link.fcs_insert_cmd === 1'b0, "mode off take");
      chk(link.msg_send_cmd === 1'b0 && term_busy === 1'b0, "mode off send");
    end
    frame_byte_valid <= 1'b0;
    hdlc_mode_en <= 1'b1;
    repeat (16) @(posedge clk);
    $display("test mode off done");
  endtask
  // Main sequence
  initial begin
    resetn = 1'b0;
    tbus_en = 1'b0;
    hdlc_mode_en = 1'b1;
    crc32_sel = 1'b0;
    frame_byte = 8'h00;
    frame_byte_valid = 1'b0;
    frame_byte_last = 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    test_idle;
    run_frame('{8'h7E, 8'h00, 8'hA5}, 1'b0);
    $display("test crc16 done");
    run_frame('{8'hFF}, 1'b1);
    $display("test crc32 done");
    test_tbus;
    test_mode_off;
    tally_and_finish;
  end
  // Watchdog
  initial begin
    #100000;
    error_cnt++;
    $display("unexpected at %0t: run hung", $time);
    tally_and_finish;
  end
endmodule
`default_nettype wire

// ===== hht_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Checker on the byte port wires
module hht_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hdlc_tx_clk,
  input wire logic msg_send_cmd,
  input wire logic fcs_insert_cmd,
  input wire logic [7:0] hdlc_tx_byte_in
);
  // Byte clock one cycle ago
  logic prev_r;
  // Byte clock rises seen with trailer high
  logic [2:0] fcs_cnt_r;
  // Byte clock rose in this cycle
  logic rise_seen;
  assign rise_seen = hdlc_tx_clk & ~prev_r;
  // ==========================================================
  // Helper counters
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_r <= 1'b0;
      fcs_cnt_r <= 3'h0;
    end else begin
      prev_r <= hdlc_tx_clk;
      // Restart count outside trailer
      if (rise_seen) begin
        fcs_cnt_r <= fcs_insert_cmd ? fcs_cnt_r + 3'h1 : 3'h0;
      end
    end
  end
  // ==========================================================
  // Assertions, byte clock half period of 4 cycles
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // High phase then low
  sequence s_high_run;
    hdlc_tx_clk [*3] ##1 !hdlc_tx_clk;
  endsequence
  // Low phase then high
  sequence s_low_run;
    !hdlc_tx_clk [*3] ##1 hdlc_tx_clk;
  endsequence
  a_clk_high_half: assert property ($rose(hdlc_tx_clk) |-> ##1 s_high_run)
    else $error("byte clock high phase wrong");
  a_clk_low_half: assert property ($fell(hdlc_tx_clk) |-> ##1 s_low_run)
    else $error("byte clock low phase wrong");
  a_trailer_len: assert property ($fell(fcs_insert_cmd) |-> fcs_cnt_r inside {3'h2, 3'h4})
    else $error("trailer period count wrong");
  a_pins_after_rise: assert property (
    $changed({msg_send_cmd, fcs_insert_cmd, hdlc_tx_byte_in}) |-> $past(rise_seen))
    else $error("port pins changed off the byte clock");
  a_fcs_with_msg: assert property (fcs_insert_cmd |-> msg_send_cmd)
    else $error("trailer without send command");
  a_start_with_data: assert property ($rose(msg_send_cmd) |-> !fcs_insert_cmd)
    else $error("frame began with trailer");
  a_trailer_ends_frame: assert property ($fell(fcs_insert_cmd) |-> !msg_send_cmd)
    else $error("send command outlived trailer");
  a_gap_after_frame: assert property ($fell(msg_send_cmd) |-> !msg_send_cmd [*7])
    else $error("no flag period between frames");
endmodule
`default_nettype wire

// ===== hht_dev.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Transmitter end: builds HDLC frames from the byte port
//
// How it works
// - Terminal drives both commands for every frame
// - Trailer insert appends computed check sequence
// - CRC-16 trailer command lasts two periods
// - CRC-32 trailer command lasts four periods
// - Send command high with trailer low latches byte each rising edge
// - Each latched byte goes out to framer
// - Send command low sends continuous 0x7E flags
// - Port works only in HDLC, telecom bus off
// - Trailer pin low outside HDLC mode
module hht_dev #(
  parameter int unsigned HALF_DIV = hht_pkg::HALF_DIV_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  hht_if.dev link,
  input wire logic tbus_en,
  input wire logic hdlc_mode_en,
  input wire logic crc32_sel,
  output logic [7:0] payload_byte,
  output logic payload_valid,
  output logic payload_is_data,
  output logic frame_active
);

  // ==========================================================
  // Local sizes
  localparam int unsigned DW = hht_pkg::DIV_W;
  // Divider value at which the byte clock toggles
  localparam logic [DW-1:0] DIV_LAST = DW'(HALF_DIV - 1);

  // ==========================================================
  // State record
  typedef struct packed {
    logic [DW-1:0] div;               // Byte clock divider
    logic tx_clk;                     // Byte clock level
    hht_pkg::hht_dev_state_t state;   // Frame sequence state
    logic [31:0] crc;                 // Running check value
    logic [2:0] fcs_idx;              // Next trailer byte index
    logic sel32;                      // Trailer size of this frame
    logic [7:0] out_byte;             // Byte to the framer
    logic out_valid;                  // Byte strobe to the framer
    logic out_data;                   // Byte is frame content
    logic active;                     // Frame under way
  } hht_dev_st_t;

  localparam hht_dev_st_t RESET_ST = '{
    div: '0,
    tx_clk: 1'b0,
    state: hht_pkg::HHT_D_IDLE,
    crc: 32'h0000_0000,
    fcs_idx: 3'h0,
    sel32: 1'b0,
    out_byte: hht_pkg::FLAG_OCTET,
    out_valid: 1'b0,
    out_data: 1'b0,
    active: 1'b0
  };

  hht_dev_st_t st_r;   // Registered state
  hht_dev_st_t st_nxt; // Next state
  logic tick;          // Byte clock rising edge, sample moment
  logic port_on;       // Byte port owns the shared pins
  logic msg;           // Qualified send command
  logic fcs;           // Qualified trailer command
  logic [2:0] last_idx; // Index of the final trailer byte

  // ==========================================================
  // Helpers

  // One byte through the reflected CRC, LSB first
  function automatic logic [31:0] crc_step(
    input logic [31:0] crc_in,
    input logic [7:0] data,
    input logic is32
  );
    logic [31:0] c;
    logic [31:0] poly;
    c = crc_in ^ {24'h00_0000, data};
    poly = is32 ? hht_pkg::CRC32_POLY : hht_pkg::CRC16_POLY;
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ poly) : (c >> 1);
    end
    return c;
  endfunction

  // Trailer length for the chosen size
  function automatic logic [2:0] fcs_len(input logic is32);
    return is32 ? hht_pkg::FCS32_LEN : hht_pkg::FCS16_LEN;
  endfunction

  // Trailer byte: inverted check value, low byte first
  function automatic logic [7:0] fcs_byte(
    input logic [31:0] crc_in,
    input logic [2:0] idx
  );
    logic [31:0] f;
    f = (~crc_in) >> {idx, 3'h0};
    return f[7:0];
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.out_valid = 1'b0;
    tick = 1'b0;
    // Byte clock divider; a rising edge is the sample moment
    if (st_r.div == DIV_LAST) begin
      st_nxt.div = '0;
      st_nxt.tx_clk = ~st_r.tx_clk;
      tick = ~st_r.tx_clk;
    end else begin
      st_nxt.div = st_r.div + {{(DW - 1){1'b0}}, 1'b1};
    end
    // shared pins only in HDLC mode with telecom bus off
    port_on = hdlc_mode_en & ~tbus_en;
    msg = port_on & link.msg_send_cmd;
    fcs = port_on & link.fcs_insert_cmd;
    last_idx = fcs_len(st_r.sel32) - 3'h1;
    if (tick) begin
      // Something goes to the framer every byte period
      st_nxt.out_valid = 1'b1;
      st_nxt.out_byte = hht_pkg::FLAG_OCTET;
      st_nxt.out_data = 1'b0;
      case (st_r.state)
        hht_pkg::HHT_D_IDLE: begin
          if (msg && !fcs) begin
            st_nxt.sel32 = crc32_sel;
            st_nxt.out_byte = link.hdlc_tx_byte_in;
            st_nxt.out_data = 1'b1;
            st_nxt.crc = crc_step(
              crc32_sel ? hht_pkg::CRC32_INIT : hht_pkg::CRC16_INIT,
              link.hdlc_tx_byte_in, crc32_sel);
            st_nxt.active = 1'b1;
            st_nxt.state = hht_pkg::HHT_D_DATA;
          end
        end
        hht_pkg::HHT_D_DATA: begin
          if (fcs) begin
            st_nxt.out_byte = fcs_byte(st_r.crc, 3'h0);
            st_nxt.fcs_idx = 3'h1;
            st_nxt.state = hht_pkg::HHT_D_FCS;
          end else if (msg) begin
            st_nxt.out_byte = link.hdlc_tx_byte_in;
            st_nxt.out_data = 1'b1;
            st_nxt.crc = crc_step(st_r.crc, link.hdlc_tx_byte_in, st_r.sel32);
          end else begin
            // send dropped, frame aborted, flag sent
            st_nxt.active = 1'b0;
            st_nxt.state = hht_pkg::HHT_D_IDLE;
          end
        end
        hht_pkg::HHT_D_FCS: begin
          if (fcs) begin
            st_nxt.out_byte = fcs_byte(st_r.crc, st_r.fcs_idx);
            st_nxt.fcs_idx = st_r.fcs_idx + 3'h1;
            if (st_r.fcs_idx == last_idx) begin
              st_nxt.active = 1'b0;
              st_nxt.state = hht_pkg::HHT_D_IDLE;
            end
          end else begin
            // Trailer cut short: close with a flag
            st_nxt.active = 1'b0;
            st_nxt.state = hht_pkg::HHT_D_IDLE;
          end
        end
        default: begin
          st_nxt.state = hht_pkg::HHT_D_IDLE;
          st_nxt.active = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= RESET_ST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs straight from the register
  assign link.hdlc_tx_clk = st_r.tx_clk;
  assign payload_byte = st_r.out_byte;
  assign payload_valid = st_r.out_valid;
  assign payload_is_data = st_r.out_data;
  assign frame_active = st_r.active;

endmodule
`default_nettype wire

// ===== hht_if.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Byte port between terminal equipment and transmitter
interface hht_if;
  // Byte clock made by the transmitter
  logic hdlc_tx_clk;
  // Message send command from the terminal
  logic msg_send_cmd;
  // Trailer insert command from the terminal
  logic fcs_insert_cmd;
  // Message byte from the terminal
  logic [7:0] hdlc_tx_byte_in;

  // Transmitter end
  modport dev (
    output hdlc_tx_clk,
    input msg_send_cmd,
    input fcs_insert_cmd,
    input hdlc_tx_byte_in
  );

  // Terminal end
  modport term (
    input hdlc_tx_clk,
    output msg_send_cmd,
    output fcs_insert_cmd,
    output hdlc_tx_byte_in
  );
endinterface
`default_nettype wire

// ===== hht_pkg.sv
// ==========================================================
// Shared constants and types of the HDLC transmit byte port
package hht_pkg;

  // Idle flag octet sent between frames
  localparam logic [7:0] FLAG_OCTET = 8'h7E;

  // Reflected CRC-16 polynomial and preset
  localparam logic [31:0] CRC16_POLY = 32'h0000_8408;
  localparam logic [31:0] CRC16_INIT = 32'h0000_FFFF;

  // Reflected CRC-32 polynomial and preset
  localparam logic [31:0] CRC32_POLY = 32'hEDB8_8320;
  localparam logic [31:0] CRC32_INIT = 32'hFFFF_FFFF;

  // Trailer length in bytes, equal to command high periods
  localparam logic [2:0] FCS16_LEN = 3'h2;
  localparam logic [2:0] FCS32_LEN = 3'h4;

  // System clock and byte clock periods in ns
  localparam int unsigned SYS_CLK_PERIOD_NS = 32'h0000_000A;
  localparam int unsigned HDLC_CLK_PERIOD_NS = 32'h0000_0050;

  // System cycles per half byte clock, rounded down, at least one
  localparam int unsigned HALF_DIV_RAW = HDLC_CLK_PERIOD_NS / (2 * SYS_CLK_PERIOD_NS);
  localparam int unsigned HALF_DIV_CYC = (HALF_DIV_RAW < 1) ? 1 : HALF_DIV_RAW;

  // Width of the byte clock divider
  localparam int unsigned DIV_W = 32'h0000_0010;

  // Transmitter sequence states
  typedef enum logic [2:0] {
    HHT_D_IDLE = 3'h1,
    HHT_D_DATA = 3'h2,
    HHT_D_FCS = 3'h4
  } hht_dev_state_t;

  // Terminal sequence states
  typedef enum logic [3:0] {
    HHT_T_IDLE = 4'h1,
    HHT_T_SEND = 4'h2,
    HHT_T_FCS = 4'h4,
    HHT_T_GAP = 4'h8
  } hht_term_state_t;

endpackage

// ===== hht_term.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Terminal end: feeds frames into the byte port
module hht_term (
  input wire logic clk,
  input wire logic resetn,
  hht_if.term link,
  input wire logic hdlc_mode_en,
  input wire logic crc32_sel,
  input wire logic [7:0] frame_byte,
  input wire logic frame_byte_valid,
  input wire logic frame_byte_last,
  output logic frame_byte_ready,
  output logic frame_done,
  output logic term_busy
);

  // ==========================================================
  // State record
  typedef struct packed {
    logic prev_clk;                    // Byte clock seen last cycle
    hht_pkg::hht_term_state_t state;   // Sequence state
    logic msg;                         // Message send pin
    logic fcs;                         // Trailer insert pin
    logic [7:0] data;                  // Byte pins
    logic [2:0] cnt;                   // Trailer periods driven
    logic sel32;                       // Trailer size of this frame
    logic ready;                       // Byte taken pulse
    logic done;                        // Frame finished pulse
  } hht_term_st_t;

  localparam hht_term_st_t RESET_ST = '{
    prev_clk: 1'b0,
    state: hht_pkg::HHT_T_IDLE,
    msg: 1'b0,
    fcs: 1'b0,
    data: 8'h00,
    cnt: 3'h0,
    sel32: 1'b0,
    ready: 1'b0,
    done: 1'b0
  };

  hht_term_st_t st_r;   // Registered state
  hht_term_st_t st_nxt; // Next state
  logic rise;           // Byte clock rising edge seen
  logic [2:0] last_cnt; // Final trailer period index

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.prev_clk = link.hdlc_tx_clk;
    st_nxt.ready = 1'b0;
    st_nxt.done = 1'b0;
    rise = link.hdlc_tx_clk & ~st_r.prev_clk;
    last_cnt = (st_r.sel32 ? hht_pkg::FCS32_LEN : hht_pkg::FCS16_LEN) - 3'h1;
    if (!hdlc_mode_en) begin
      st_nxt.state = hht_pkg::HHT_T_IDLE;
      st_nxt.msg = 1'b0;
      st_nxt.fcs = 1'b0;
    end else if (rise) begin
      case (st_r.state)
        hht_pkg::HHT_T_IDLE: begin
          // Start a frame once a byte waits
          st_nxt.msg = frame_byte_valid;
          st_nxt.fcs = 1'b0;
          if (frame_byte_valid) begin
            st_nxt.data = frame_byte;
            st_nxt.ready = 1'b1;
            st_nxt.sel32 = crc32_sel;
            st_nxt.state = frame_byte_last ? hht_pkg::HHT_T_FCS : hht_pkg::HHT_T_SEND;
          end
        end
        hht_pkg::HHT_T_SEND: begin
          // Next byte, or abort on underrun
          st_nxt.msg = frame_byte_valid;
          if (frame_byte_valid) begin
            st_nxt.data = frame_byte;
            st_nxt.ready = 1'b1;
            if (frame_byte_last) begin
              st_nxt.state = hht_pkg::HHT_T_FCS;
            end
          end else begin
            st_nxt.state = hht_pkg::HHT_T_IDLE;
          end
        end
        hht_pkg::HHT_T_FCS: begin
          st_nxt.msg = 1'b1;
          st_nxt.fcs = 1'b1;
          if (st_r.cnt == last_cnt) begin
            st_nxt.cnt = 3'h0;
            st_nxt.state = hht_pkg::HHT_T_GAP;
          end else begin
            st_nxt.cnt = st_r.cnt + 3'h1;
          end
        end
        hht_pkg::HHT_T_GAP: begin
          // One low period so a flag closes the frame
          st_nxt.msg = 1'b0;
          st_nxt.fcs = 1'b0;
          st_nxt.done = 1'b1;
          st_nxt.state = hht_pkg::HHT_T_IDLE;
        end
        default: begin
          st_nxt = RESET_ST;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= RESET_ST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Pins and user outputs straight from the register
  assign link.msg_send_cmd = st_r.msg;
  assign link.fcs_insert_cmd = st_r.fcs;
  assign link.hdlc_tx_byte_in = st_r.data;
  assign frame_byte_ready = st_r.ready;
  assign frame_done = st_r.done;
  assign term_busy = st_r.msg;

endmodule
`default_nettype wire
